// ==== sbt_subtimer.sv ====
// Calibrated ring-oscillator subtimer with AXI4-Lite register access
// Overview of operation
// [RQ1] Control bit gates subclock supply to the chip; 0 off, 1 on. The code turns supply on only while the oscillator enable bit is also 1.
// [RQ2] Interrupt enable 1 lets the underflow flag raise a request.
// [RQ3] Counter underflow sets the flag and issues a gated request.
// [RQ4] Flag clears only on a 0 write after it was read as 1.
// [RQ5] Eight-bit down counter readable and writable at any time.
// [RQ6] Counter resets to all ones.
// [RQ7] With oscillator enabled, count clocks from first to third falling edge.
// [RQ8] Measured count loads the ratio register, which sets the division.
// [RQ9] Ratio register is eight bits, read/write, resets to all ones.
// [RQ10] Counter decrements per subclock tick and wraps from zero to all ones.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module sbt_subtimer (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ringOscIn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic subclockTick,
    output logic chip_subclock_supply_en,
    output logic underflowIrq
);
    import sbt_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [3:0] awAddr, next_awAddr;
    logic awHave, next_awHave;
    logic [31:0] wData, next_wData;
    logic wStrb0, next_wStrb0;
    logic wHave, next_wHave;
    logic bValid, next_bValid;
    logic [1:0] bResp, next_bResp;
    logic rValid, next_rValid;
    logic [31:0] rData, next_rData;
    logic [1:0] rResp, next_rResp;
    logic [7:0] subtimer_down_counter, next_subtimer_down_counter;
    logic [7:0] ring_osc_prescale_ratio, next_ring_osc_prescale_ratio;
    logic underflow_flag, next_underflow_flag;
    logic underflow_irq_enable, next_underflow_irq_enable;
    logic supplyEn, next_supplyEn;
    logic ring_osc_enable, next_ring_osc_enable;
    logic flagSeen, next_flagSeen;
    logic [7:0] divCount, next_divCount;
    logic tick, next_tick;
    logic [7:0] calibration_prescaler, next_calibration_prescaler;
    logic [1:0] edgeCount, next_edgeCount;
    sbt_cal_type calState, next_calState;
    logic oscMeta, oscSync, oscPrev;

    logic doWrite;
    logic doRead;
    logic fallEdge;
    logic underflow;

    assign doWrite = awHave && wHave && !bValid;
    assign doRead = s_axi_arvalid && !rValid;
    assign fallEdge = oscPrev && !oscSync;
    // Wrap from zero counts as the underflow event
    assign underflow = tick && (subtimer_down_counter == 8'h00); // [RQ3]

    assign s_axi_awready = !awHave;
    assign s_axi_wready = !wHave;
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;
    assign s_axi_arready = !rValid;
    assign s_axi_rvalid = rValid;
    assign s_axi_rdata = rData;
    assign s_axi_rresp = rResp;
    assign subclockTick = tick;
    assign chip_subclock_supply_en = supplyEn && ring_osc_enable; // [RQ1]
    assign underflowIrq = underflow_flag && underflow_irq_enable; // [RQ2]

    // ------------------------------------------------------------------
    // Oscillator synchroniser
    // ------------------------------------------------------------------
    // Ring oscillator is asynchronous to core_clk
    always_ff @(posedge core_clk) begin
        if (rst) begin
            oscMeta <= 1'b0;
            oscSync <= 1'b0;
            oscPrev <= 1'b0;
        end else begin
            oscMeta <= ringOscIn;
            oscSync <= oscMeta;
            oscPrev <= oscSync;
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_awAddr = awAddr;
        next_awHave = awHave;
        next_wData = wData;
        next_wStrb0 = wStrb0;
        next_wHave = wHave;
        next_bValid = bValid;
        next_bResp = bResp;
        next_rValid = rValid;
        next_rData = rData;
        next_rResp = rResp;
        next_subtimer_down_counter = subtimer_down_counter;
        next_ring_osc_prescale_ratio = ring_osc_prescale_ratio;
        next_underflow_flag = underflow_flag;
        next_underflow_irq_enable = underflow_irq_enable;
        next_supplyEn = supplyEn;
        next_ring_osc_enable = ring_osc_enable;
        next_flagSeen = flagSeen;
        next_divCount = divCount;
        next_tick = 1'b0;
        next_calibration_prescaler = calibration_prescaler;
        next_edgeCount = edgeCount;
        next_calState = calState;

        if (s_axi_awvalid && !awHave) begin
            next_awAddr = s_axi_awaddr;
            next_awHave = 1'b1;
        end
        if (s_axi_wvalid && !wHave) begin
            next_wData = s_axi_wdata;
            next_wStrb0 = s_axi_wstrb[0];
            next_wHave = 1'b1;
        end
        if (bValid && s_axi_bready) begin
            next_bValid = 1'b0;
        end
        if (rValid && s_axi_rready) begin
            next_rValid = 1'b0;
        end

        // Subclock divider: one tick every ratio+1 clocks
        if (divCount >= ring_osc_prescale_ratio) begin
            next_divCount = 8'h00;
            next_tick = 1'b1; // [RQ8]
        end else begin
            next_divCount = divCount + 8'h01;
        end
        if (tick) begin
            next_subtimer_down_counter = subtimer_down_counter - 8'h01; // [RQ10]
        end

        // Calibration of ratio against the oscillator
        case (calState)
            CAL_IDLE: begin
                if (ring_osc_enable) begin
                    next_calState = CAL_WAIT;
                end
            end
            CAL_WAIT: begin
                if (fallEdge) begin
                    next_calibration_prescaler = 8'h00;
                    next_edgeCount = 2'h0;
                    next_calState = CAL_COUNT; // [RQ7]
                end
            end
            CAL_COUNT: begin
                next_calibration_prescaler = calibration_prescaler + 8'h01;
                if (fallEdge) begin
                    next_edgeCount = edgeCount + 2'h1;
                    if (edgeCount + 2'h1 == SBT_CAL_EDGES) begin
                        next_ring_osc_prescale_ratio = calibration_prescaler; // [RQ8]
                        next_calState = CAL_DONE;
                    end
                end
            end
            default: begin
                if (!ring_osc_enable) begin
                    next_calState = CAL_IDLE;
                end
            end
        endcase
        if (!ring_osc_enable) begin
            next_calState = CAL_IDLE;
        end

        if (doRead) begin
            next_rValid = 1'b1;
            next_rResp = SBT_RESP_OKAY;
            next_rData = 32'h0000_0000;
            if (s_axi_araddr == SBT_OFF_CONTROL) begin
                next_rData[SBT_BIT_FLAG] = underflow_flag;
                next_rData[SBT_BIT_IRQEN] = underflow_irq_enable;
                next_rData[SBT_BIT_SUPPLY] = supplyEn;
                next_rData[SBT_BIT_OSCEN] = ring_osc_enable;
                if (underflow_flag) begin
                    next_flagSeen = 1'b1; // [RQ4]
                end
            end else if (s_axi_araddr == SBT_OFF_COUNTER) begin
                next_rData[7:0] = subtimer_down_counter; // [RQ5]
            end else if (s_axi_araddr == SBT_OFF_RATIO) begin
                next_rData[7:0] = ring_osc_prescale_ratio; // [RQ9]
            end else begin
                next_rResp = SBT_RESP_SLVERR;
            end
        end

        if (doWrite) begin
            next_awHave = 1'b0;
            next_wHave = 1'b0;
            next_bValid = 1'b1;
            next_bResp = SBT_RESP_OKAY;
            if (awAddr == SBT_OFF_CONTROL) begin
                if (wStrb0) begin
                    next_underflow_irq_enable = wData[SBT_BIT_IRQEN];
                    next_supplyEn = wData[SBT_BIT_SUPPLY];
                    next_ring_osc_enable = wData[SBT_BIT_OSCEN];
                    if (!wData[SBT_BIT_FLAG] && flagSeen) begin
                        next_underflow_flag = 1'b0; // [RQ4]
                        next_flagSeen = 1'b0;
                    end
                end
            end else if (awAddr == SBT_OFF_COUNTER) begin
                if (wStrb0) begin
                    next_subtimer_down_counter = wData[7:0]; // [RQ5]
                end
            end else if (awAddr == SBT_OFF_RATIO) begin
                if (wStrb0) begin
                    next_ring_osc_prescale_ratio = wData[7:0]; // [RQ9]
                end
            end else begin
                next_bResp = SBT_RESP_SLVERR;
            end
        end

        // Set wins over a simultaneous clear
        if (underflow) begin
            next_underflow_flag = 1'b1; // [RQ3]
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            awAddr <= 4'h0;
            awHave <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb0 <= 1'b0;
            wHave <= 1'b0;
            bValid <= 1'b0;
            bResp <= SBT_RESP_OKAY;
            rValid <= 1'b0;
            rData <= 32'h0000_0000;
            rResp <= SBT_RESP_OKAY;
            subtimer_down_counter <= SBT_RST_COUNTER; // [RQ6]
            ring_osc_prescale_ratio <= SBT_RST_RATIO; // [RQ9]
            underflow_flag <= 1'b0;
            underflow_irq_enable <= 1'b0;
            supplyEn <= 1'b0;
            ring_osc_enable <= 1'b0;
            flagSeen <= 1'b0;
            divCount <= 8'h00;
            tick <= 1'b0;
            calibration_prescaler <= 8'h00;
            edgeCount <= 2'h0;
            calState <= CAL_IDLE;
        end else begin
            awAddr <= next_awAddr;
            awHave <= next_awHave;
            wData <= next_wData;
            wStrb0 <= next_wStrb0;
            wHave <= next_wHave;
            bValid <= next_bValid;
            bResp <= next_bResp;
            rValid <= next_rValid;
            rData <= next_rData;
            rResp <= next_rResp;
            subtimer_down_counter <= next_subtimer_down_counter;
            ring_osc_prescale_ratio <= next_ring_osc_prescale_ratio;
            underflow_flag <= next_underflow_flag;
            underflow_irq_enable <= next_underflow_irq_enable;
            supplyEn <= next_supplyEn;
            ring_osc_enable <= next_ring_osc_enable;
            flagSeen <= next_flagSeen;
            divCount <= next_divCount;
            tick <= next_tick;
            calibration_prescaler <= next_calibration_prescaler;
            edgeCount <= next_edgeCount;
            calState <= next_calState;
        end
    end
endmodule // sbt_subtimer

// ==== sbt_pkg.sv ====
// Package with register map and constants for the calibrated subtimer
package sbt_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] SBT_OFF_CONTROL = 4'h0;
    localparam logic [3:0] SBT_OFF_COUNTER = 4'h4;
    localparam logic [3:0] SBT_OFF_RATIO = 4'h8;
    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int SBT_BIT_FLAG = 0;
    localparam int SBT_BIT_IRQEN = 1;
    localparam int SBT_BIT_SUPPLY = 2;
    localparam int SBT_BIT_OSCEN = 3;
    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] SBT_RST_COUNTER = 8'hFF;
    localparam logic [7:0] SBT_RST_RATIO = 8'hFF;
    localparam logic [1:0] SBT_CAL_EDGES = 2'h2;
    localparam logic [1:0] SBT_RESP_OKAY = 2'h0;
    localparam logic [1:0] SBT_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT, CAL_COUNT, CAL_DONE} sbt_cal_type;
endpackage

// ==== sbt_subtimer_properties.sv ====
// Port-level assertions for the calibrated subtimer
`timescale 1ns/1ps
module sbt_subtimer_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic subclockTick,
    input wire logic chip_subclock_supply_en,
    input wire logic underflowIrq
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && !s_axi_bvalid;
    endsequence
    // Held pair executes one cycle later, so the answer comes a cycle after
    sequence wrAnswer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_reset_quiet: assert property ($past(rst) |-> !underflowIrq
        && !chip_subclock_supply_en && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
    a_write_answer: assert property (wrTaken |=> wrAnswer)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read response missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid) else $error("rvalid dropped");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    // Supply only moves on a register write
    a_supply_write: assert property ($changed(chip_subclock_supply_en)
        |-> $rose(s_axi_bvalid)) else $error("supply changed without write");
    a_irq_cause: assert property ($rose(underflowIrq)
        |-> $past(subclockTick) || $rose(s_axi_bvalid))
        else $error("request rose without tick or write");
    a_irq_clear: assert property ($fell(underflowIrq)
        |-> $rose(s_axi_bvalid)) else $error("request fell without write");
endmodule // sbt_subtimer_properties

bind sbt_subtimer sbt_subtimer_properties u_props (.*);

// ==== sbt_subtimer_tb.sv ====
// Self-checking bench for the calibrated subtimer
`timescale 1ns/1ps
module sbt_subtimer_tb;
    import sbt_pkg::*;
    logic core_clk, rst, ringOscIn, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, v;
    logic awready, wready, bvalid, arready, rvalid, tick, supply, irq;
    logic [1:0] bresp, rresp, r;
    int nFail, samplesChecked, cycles, oscCnt, c, mRatio, mCnt;
    sbt_subtimer DUT (.core_clk(core_clk), .rst(rst), .ringOscIn(ringOscIn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .subclockTick(tick),
        .chip_subclock_supply_en(supply), .underflowIrq(irq));
    // ------------------------------------------------------------------
    // Clock, ring oscillator and hang guard
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Oscillator period of 40 clocks, so calibration should land near 80
    always @(posedge core_clk) begin
        oscCnt <= (oscCnt == 19) ? 0 : oscCnt + 1;
        if (oscCnt == 19) ringOscIn <= ~ringOscIn;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nFail++;
            giveVerdict();
        end
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] s, input logic [31:0] e);
        samplesChecked++;
        if (s !== e) begin
            nFail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task ticks(input int n);
        repeat (n) begin
            @(posedge core_clk);
            while (tick !== 1'b1) @(posedge core_clk);
        end
    endtask
    task giveVerdict;
        if (nFail == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, ringOscIn, oscCnt, cycles, nFail, samplesChecked} = '0;
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        c = $urandom(67);
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(SBT_OFF_COUNTER);
        chk(v, 32'h0000_00FF);
        chk(32'(r), 32'(SBT_RESP_OKAY));
        rd(SBT_OFF_RATIO);
        chk(v, 32'h0000_00FF);
        rd(4'hC);
        chk(32'(r), 32'(SBT_RESP_SLVERR));
        wr(4'hC, 32'h0000_0001);
        chk(32'(r), 32'(SBT_RESP_SLVERR));
        for (int i = 0; i < 4; i++) begin
            mRatio = $urandom_range(255, 0);
            wr(SBT_OFF_RATIO, mRatio);
            rd(SBT_OFF_RATIO);
            chk(v, mRatio);
        end
        wr(SBT_OFF_RATIO, 32'h0000_00FF);
        chk(32'(r), 32'(SBT_RESP_OKAY));
        // Low strobe bit clear: the write must leave the ratio alone
        wstrb <= 4'hE;
        wr(SBT_OFF_RATIO, 32'h0000_0012);
        wstrb <= 4'hF;
        rd(SBT_OFF_RATIO);
        chk(v, 32'h0000_00FF);
        // Synced to a tick so no decrement lands between write and read
        for (int i = 0; i < 4; i++) begin
            mCnt = $urandom_range(255, 2);
            ticks(1);
            wr(SBT_OFF_COUNTER, mCnt);
            rd(SBT_OFF_COUNTER);
            chk(v, mCnt);
        end
        ticks(1);
        wr(SBT_OFF_COUNTER, 32'h0000_0001);
        ticks(2);
        @(posedge core_clk);
        chk(32'(irq), 32'h0);
        rd(SBT_OFF_COUNTER);
        chk(v, 32'h0000_00FF);
        wr(SBT_OFF_CONTROL, 32'h0000_0002);
        chk(32'(irq), 32'h1);
        rd(SBT_OFF_CONTROL);
        chk(v, 32'h0000_0003);
        wr(SBT_OFF_CONTROL, 32'h0000_0002);
        chk(32'(irq), 32'h0);
        rd(SBT_OFF_CONTROL);
        chk(v, 32'h0000_0002);
        wr(SBT_OFF_CONTROL, 32'h0000_0006);
        chk(32'(supply), 32'h0);
        wr(SBT_OFF_CONTROL, 32'h0000_000E);
        chk(32'(supply), 32'h1);
        do rd(SBT_OFF_RATIO); while (v === 32'h0000_00FF);
        chk(32'(v >= 79 && v <= 81), 32'h1);
        mRatio = $urandom_range(60, 20);
        wr(SBT_OFF_RATIO, mRatio);
        ticks(2);
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while (tick !== 1'b1);
        chk(c, mRatio + 1);
        // Mid-run reset must bring back the supply, ratio and counter reset values
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        chk(32'(supply), 32'h0);
        rd(SBT_OFF_RATIO);
        chk(v, 32'h0000_00FF);
        rd(SBT_OFF_COUNTER);
        chk(v, 32'h0000_00FF);
        wr(SBT_OFF_CONTROL, 32'h0000_0002);
        chk(32'(supply), 32'h0);
        giveVerdict();
    end
endmodule // sbt_subtimer_tb
